// *** rtl/can_send_pkg.sv ***
// package of constants and types for the periodic can signal send packer
package can_send_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00; // enable, rate, id mode, auto, counter format
  localparam logic [7:0] REG_FIRST_ID = 8'h04; // first identifier
  localparam logic [7:0] REG_CNT_CFG = 8'h08; // counter start bit and length
  localparam logic [7:0] REG_STATUS  = 8'h0c; // sticky events, write one to clear
  localparam logic [7:0] REG_MASK    = 8'h10; // interrupt mask
  localparam logic [7:0] REG_ERR_CNT = 8'h14; // send error count
  localparam logic [7:0] REG_SEND_CNT = 8'h18; // current send counter
  localparam logic [7:0] REG_SIG_CFG = 8'h20; // per-signal config, 4 bytes per signal
  localparam logic [7:0] REG_SIG_ID  = 8'h40; // per-signal manual identifier
  // control field positions
  localparam int CTRL_EN     = 0;
  localparam int CTRL_RATE_LO = 1;
  localparam int CTRL_EXT    = 4;
  localparam int CTRL_AUTO   = 5;
  localparam int CTRL_CNT_BE = 6;
  localparam int CTRL_BUS_LO = 8;
  // status bit positions
  localparam int ST_OVF  = 0;
  localparam int ST_SERR = 1;
  localparam int ST_SENT = 2;
  localparam int ST_W    = 3;
  // frame geometry
  localparam int DATA_BITS = 64;
  localparam int MAX_CNT_BITS = 32;
  // clock and output rate table, rates in tenths of hz
  localparam longint CLK_HZ = 100_000_000;
  localparam int NUM_RATES = 8;
  // rate codes 0..7 -> 0.5,1,2,5,10,20,50,100 Hz, expressed in tenths of hz
  localparam int RATE_DHZ [NUM_RATES] = '{5, 10, 20, 50, 100, 200, 500, 1000};
  // per-signal configuration word
  typedef struct packed {
    logic       en;      // signal selected
    logic       be;      // big-endian forward order
    logic [5:0] len;     // bit count minus one
    logic [5:0] start;   // start bit
  } sig_cfg_t;
  // one frame toward the can controller
  typedef struct packed {
    logic        ext;    // 29-bit identifier
    logic [28:0] id;     // identifier
    logic [3:0]  dlc;    // data length
    logic [63:0] data;   // payload, byte 0 in bits 7:0
  } can_frame_t;
  // packer states
  typedef enum logic [2:0] {S_IDLE, S_CAPTURE, S_BUILD, S_SEND, S_WAIT} pack_state_t;
endpackage

// *** rtl/bit_place.sv ***
`timescale 1ns/1ps
// places a value into a 64-bit payload at a start bit, length and byte order
module bit_place
  import can_send_pkg::*;
(
  input  wire logic [DATA_BITS-1:0] data_i,   // payload before insertion
  input  wire logic [31:0]          value_i,  // value to insert
  input  wire logic [5:0]           start_i,  // start bit
  input  wire logic [5:0]           len_i,    // bit count minus one
  input  wire logic                 be_i,     // big-endian forward
  output logic      [DATA_BITS-1:0] data_o    // payload after insertion
);
  // little-endian: bit k goes to start+k; big-endian forward: bytes walk
  // upward while bits walk down inside a byte from the start bit msb
  always_comb begin
    int pos;
    int off;
    data_o = data_i;
    pos = 0;
    off = 0;
    for (int k = 0; k < MAX_CNT_BITS; k++) begin
      if (k <= int'(len_i)) begin
        if (!be_i) begin
          pos = int'(start_i) + k;
        end else begin
          // distance from bit 7 of the start bit's byte, counted along the byte stream
          off = (7 - int'(start_i) % 8) + (int'(len_i) - k);
          pos = (int'(start_i) / 8 + off / 8) * 8 + 7 - off % 8;
        end
        if (pos >= 0 && pos < DATA_BITS) begin
          data_o[pos] = value_i[k];
        end
      end
    end
  end
endmodule

// *** rtl/can_signal_send_packer.sv ***
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// periodic packer of signal values into classic can data frames
module can_signal_send_packer
  import can_send_pkg::*;
#(
  parameter int NUM_SIG  = 8,  // signals handled
  parameter int SIG_W    = 32, // width of one signal value
  parameter int NUM_BUS  = 4,  // can buses of the logger
  parameter longint CLK_FREQ_HZ = CLK_HZ // clock rate the output periods are counted from
) (
  input  wire logic                     clk_i,        // system clock
  input  wire logic                     rst_i,        // synchronous reset
  // classic wishbone slave
  input  wire logic                     cyc_i,        // cycle
  input  wire logic                     stb_i,        // strobe
  input  wire logic                     we_i,         // write enable
  input  wire logic [7:0]               adr_i,        // byte address
  input  wire logic [3:0]               sel_i,        // byte lanes
  input  wire logic [31:0]              dat_i,        // write data
  output logic      [31:0]              dat_o,        // read data
  output logic                          ack_o,        // acknowledge
  // signal sources
  input  wire logic [NUM_SIG*SIG_W-1:0] sig_val_i,    // latest values
  input  wire logic [NUM_SIG-1:0]       sig_new_i,    // new sample pulse per signal
  // can controller side
  output can_frame_t                    frame_o,      // frame to send
  output logic                          frame_vld_o,  // frame request level
  output logic      [NUM_BUS-1:0]       bus_sel_o,    // one-hot bus select
  input  wire logic                     frame_done_i, // controller finished frame
  input  wire logic                     frame_ack_i,  // frame was acknowledged
  output logic                          irq_o         // level interrupt
);
  // refuse sizes the packer cannot serve; a clock too slow gives empty periods
  if (NUM_SIG < 1 || NUM_SIG > 8 || SIG_W < 1 || SIG_W > 32 || NUM_BUS < 1 || NUM_BUS > 16
      || CLK_FREQ_HZ < 100 || CLK_FREQ_HZ > 2_000_000_000) begin : g_bad_params
    $error("can_signal_send_packer: unsupported parameters");
  end

  localparam int BW = (NUM_BUS > 1) ? $clog2(NUM_BUS) : 1;
  localparam int IW = (NUM_SIG > 1) ? $clog2(NUM_SIG) : 1;

  // software registers
  logic [31:0]          ctrl_r;      // control word
  logic [28:0]          first_id_r;  // first automatic identifier
  logic [5:0]           cnt_start_r; // counter start bit
  logic [5:0]           cnt_len_r;   // counter length minus one
  logic [ST_W-1:0]      status_r;    // sticky events
  logic [ST_W-1:0]      mask_r;      // interrupt mask
  logic [15:0]          err_cnt_r;   // send error count
  logic [31:0]          send_cnt_r;  // send counter
  sig_cfg_t             sig_cfg_r [NUM_SIG]; // per-signal placement
  logic [28:0]          sig_id_r  [NUM_SIG]; // per-signal manual identifier
  logic [SIG_W-1:0]     snap_r    [NUM_SIG]; // captured values
  logic [NUM_SIG-1:0]   fresh_r;     // new sample seen since last tick

  // control field views
  logic       en;
  logic [2:0] rate;
  logic       ext;
  logic       auto_on;
  logic       cnt_be;
  logic [BW-1:0] bus;
  assign en      = ctrl_r[CTRL_EN];
  assign rate    = ctrl_r[CTRL_RATE_LO +: 3];
  assign ext     = ctrl_r[CTRL_EXT];
  assign auto_on = ctrl_r[CTRL_AUTO];
  assign cnt_be  = ctrl_r[CTRL_CNT_BE];
  assign bus     = ctrl_r[CTRL_BUS_LO +: BW];

  // event pulses from the packer
  logic ev_ovf;   // selected source had no new sample at the tick
  logic ev_serr;  // unacknowledged frame
  logic ev_sent;  // period finished

  // bus access decode
  logic        acc;
  logic        wr;
  assign acc = cyc_i && stb_i && !ack_o;
  assign wr  = acc && we_i;

  // acknowledge one cycle after strobe, drop the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= acc;
    end
  end

  // read mux, unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (acc && !we_i) begin
      dat_o <= 32'h0;
      if (adr_i >= REG_SIG_ID) begin
        if (int'(adr_i - REG_SIG_ID) / 4 < NUM_SIG)
          dat_o <= {3'h0, sig_id_r[IW'((adr_i - REG_SIG_ID) >> 2)]};
      end else if (adr_i >= REG_SIG_CFG) begin
        if (int'(adr_i - REG_SIG_CFG) / 4 < NUM_SIG)
          dat_o <= {18'h0, sig_cfg_r[IW'((adr_i - REG_SIG_CFG) >> 2)]};
      end else begin
        case (adr_i)
          REG_CTRL:     dat_o <= ctrl_r;
          REG_FIRST_ID: dat_o <= {3'h0, first_id_r};
          REG_CNT_CFG:  dat_o <= {18'h0, cnt_len_r, 2'h0, cnt_start_r};
          REG_STATUS:   dat_o <= {29'h0, status_r};
          REG_MASK:     dat_o <= {29'h0, mask_r};
          REG_ERR_CNT:  dat_o <= {16'h0, err_cnt_r};
          REG_SEND_CNT: dat_o <= send_cnt_r;
          default:      dat_o <= 32'h0;
        endcase
      end
    end
  end

  // configuration writes; ctrl and counter config honour byte lanes, identifiers and signal config need all their lanes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r      <= 32'h0;
      first_id_r  <= 29'h0;
      cnt_start_r <= 6'h0;
      cnt_len_r   <= 6'h7;
      mask_r      <= '0;
      for (int i = 0; i < NUM_SIG; i++) begin
        sig_cfg_r[i] <= '0;
        sig_id_r[i]  <= 29'h0;
      end
    end else if (wr) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          if (adr_i == REG_CTRL) ctrl_r[b*8 +: 8] <= dat_i[b*8 +: 8];
        end
      end
      if (adr_i == REG_FIRST_ID && &sel_i) first_id_r <= dat_i[28:0];
      if (adr_i == REG_CNT_CFG && sel_i[0]) cnt_start_r <= dat_i[5:0];
      if (adr_i == REG_CNT_CFG && sel_i[1]) cnt_len_r <= dat_i[13:8];
      if (adr_i == REG_MASK && sel_i[0]) mask_r <= dat_i[ST_W-1:0];
      for (int i = 0; i < NUM_SIG; i++) begin
        if (adr_i == REG_SIG_CFG + 8'(4*i) && sel_i[1:0] == 2'b11)
          sig_cfg_r[i] <= dat_i[13:0];
        if (adr_i == REG_SIG_ID + 8'(4*i) && &sel_i)
          sig_id_r[i] <= dat_i[28:0];
      end
    end
  end

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= '0;
    end else begin
      logic [ST_W-1:0] set;
      set = '0;
      set[ST_OVF]  = ev_ovf;
      set[ST_SERR] = ev_serr;
      set[ST_SENT] = ev_sent;
      if (wr && adr_i == REG_STATUS && sel_i[0])
        status_r <= (status_r & ~dat_i[ST_W-1:0]) | set;
      else
        status_r <= status_r | set;
    end
  end

  // interrupt level from unmasked status
  always_ff @(posedge clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else irq_o <= |(status_r & mask_r);
  end

  // rate divider: one tick per output period
  logic [31:0] period;
  logic [31:0] div_r;
  logic        tick;
  always_comb begin
    period = 32'((CLK_FREQ_HZ * 10) / RATE_DHZ[0]);
    for (int r = 0; r < NUM_RATES; r++)
      if (rate == 3'(r)) period = 32'((CLK_FREQ_HZ * 10) / RATE_DHZ[r]);
  end
  assign tick = en && (div_r >= period - 32'h1);
  always_ff @(posedge clk_i) begin
    if (rst_i || !en || tick) div_r <= 32'h0;
    else div_r <= div_r + 32'h1;
  end

  // sample tracking: a source with no new sample since the last tick means
  // the output rate is not below its acquisition rate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fresh_r <= '0;
      ev_ovf  <= 1'b0;
    end else begin
      ev_ovf <= 1'b0;
      if (tick) begin
        for (int i = 0; i < NUM_SIG; i++)
          if (sig_cfg_r[i].en && !fresh_r[i]) ev_ovf <= 1'b1;
        fresh_r <= sig_new_i;
      end else begin
        fresh_r <= fresh_r | sig_new_i;
      end
    end
  end

  // capture latest values on the tick
  genvar g;
  generate
    for (g = 0; g < NUM_SIG; g++) begin : g_snap
      always_ff @(posedge clk_i) begin
        if (rst_i) snap_r[g] <= '0;
        else if (tick) snap_r[g] <= sig_val_i[g*SIG_W +: SIG_W];
      end
    end
  endgenerate

  // packer state
  pack_state_t state_r;
  logic [IW:0] idx_r;      // signal index in this frame pass
  logic [IW:0] msg_r;      // message number in auto mode
  logic [DATA_BITS-1:0] pay_r;
  logic [DATA_BITS-1:0] pay_nxt;
  logic [31:0] ins_val;
  logic [5:0]  ins_start;
  logic [5:0]  ins_len;
  logic        ins_be;
  logic        cnt_phase_r; // counter insertion step pending

  // select what is inserted: counter first in auto message 0, then signal
  always_comb begin
    ins_val   = 32'h0;
    ins_start = cnt_start_r;
    ins_len   = cnt_len_r;
    ins_be    = cnt_be;
    if (cnt_phase_r) begin
      ins_val = send_cnt_r;
    end else if (idx_r < (IW+1)'(NUM_SIG)) begin
      ins_val   = 32'(snap_r[IW'(idx_r)]);
      ins_start = sig_cfg_r[IW'(idx_r)].start;
      ins_len   = sig_cfg_r[IW'(idx_r)].len;
      ins_be    = sig_cfg_r[IW'(idx_r)].be;
    end
  end

  bit_place u_place (
    .data_i  (pay_r),
    .value_i (ins_val),
    .start_i (ins_start),
    .len_i   (ins_len),
    .be_i    (ins_be),
    .data_o  (pay_nxt)
  );

  // frame builder: one frame per signal; in auto mode the counter goes out
  // alone first, then the signals, with consecutive identifiers from the first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= S_IDLE;
      idx_r       <= '0;
      msg_r       <= '0;
      pay_r       <= '0;
      cnt_phase_r <= 1'b0;
      frame_o     <= '0;
      frame_vld_o <= 1'b0;
      ev_serr     <= 1'b0;
      ev_sent     <= 1'b0;
      err_cnt_r   <= 16'h0;
      send_cnt_r  <= 32'h0;
    end else begin
      ev_serr <= 1'b0;
      ev_sent <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (tick) begin
            idx_r       <= '0;
            msg_r       <= '0;
            cnt_phase_r <= auto_on;
            pay_r       <= '0;
            state_r     <= S_CAPTURE;
          end
        end
        S_CAPTURE: begin
          // skip unselected signals
          if (!cnt_phase_r && idx_r < (IW+1)'(NUM_SIG) && !sig_cfg_r[IW'(idx_r)].en)
            idx_r <= idx_r + 1'b1;
          else if (!cnt_phase_r && idx_r >= (IW+1)'(NUM_SIG)) begin
            // period done, counter counts one task
            if (cnt_len_r == 6'(MAX_CNT_BITS-1) ? &send_cnt_r
                : send_cnt_r == (32'h1 << (cnt_len_r + 6'h1)) - 32'h1)
              send_cnt_r <= 32'h0;
            else
              send_cnt_r <= send_cnt_r + 32'h1;
            ev_sent <= 1'b1;
            state_r <= S_IDLE;
          end else
            state_r <= S_BUILD;
        end
        S_BUILD: begin
          pay_r <= pay_nxt;
          if (cnt_phase_r) begin
            cnt_phase_r <= 1'b0;
            state_r     <= S_SEND;
          end else begin
            idx_r   <= idx_r + 1'b1;
            state_r <= S_SEND;
          end
        end
        S_SEND: begin
          frame_o.ext  <= ext;
          frame_o.id   <= auto_on ? first_id_r + 29'(msg_r)
                                  : sig_id_r[IW'(idx_r - 1'b1)];
          if (!ext) frame_o.id <= {18'h0, (auto_on ? first_id_r[10:0] + 11'(msg_r)
                                                  : sig_id_r[IW'(idx_r - 1'b1)][10:0])};
          frame_o.dlc  <= 4'h8;
          frame_o.data <= pay_r;
          frame_vld_o  <= 1'b1;
          state_r      <= S_WAIT;
        end
        S_WAIT: begin
          if (frame_done_i) begin
            frame_vld_o <= 1'b0;
            if (!frame_ack_i) begin
              ev_serr   <= 1'b1;
              err_cnt_r <= err_cnt_r + 16'h1;
              state_r   <= S_SEND; // retry until a node acknowledges
            end else begin
              msg_r   <= msg_r + 1'b1;
              pay_r   <= '0;
              state_r <= S_CAPTURE;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // single bus select
  always_ff @(posedge clk_i) begin
    if (rst_i) bus_sel_o <= '0;
    else bus_sel_o <= en ? (NUM_BUS'(1) << bus) : '0;
  end
endmodule

// *** sim/send_packer_checker_assertions.sv ***
// concurrent checks on the ports of the can signal send packer
`timescale 1ns/1ps
module send_packer_checker
  import can_send_pkg::*;
#(
  parameter int NUM_BUS = 4 // can buses of the logger
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               cyc_i,
  input wire logic               stb_i,
  input wire logic               we_i,
  input wire logic [7:0]         adr_i,
  input wire logic [31:0]        dat_i,
  input wire logic [31:0]        dat_o,
  input wire logic               ack_o,
  input wire can_frame_t         frame_o,
  input wire logic               frame_vld_o,
  input wire logic [NUM_BUS-1:0] bus_sel_o,
  input wire logic               frame_done_i,
  input wire logic               frame_ack_i,
  input wire logic               irq_o
);
  localparam int BW = $clog2(NUM_BUS); // width of the bus index field
  logic [31:0] ctrl_r; // mirror of the control register
  logic [31:0] mask_r; // mirror of the mask register
  logic        pend_r; // a refused frame still awaits its resend
  logic [28:0] nid_r;  // identifier of the refused frame
  logic        wr_ok;  // acknowledged write
  assign wr_ok = cyc_i && stb_i && we_i && ack_o;
  // mirror control and mask writes at the acknowledging edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= '0;
      mask_r <= '0;
    end else if (wr_ok && adr_i == REG_CTRL) begin
      ctrl_r <= dat_i;
    end else if (wr_ok && adr_i == REG_MASK) begin
      mask_r <= dat_i;
    end
  end
  // remember which frame the far side refused
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
      nid_r  <= '0;
    end else if (frame_vld_o && frame_done_i) begin
      pend_r <= !frame_ack_i;
      nid_r  <= frame_o.id;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_follows_req:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_single_pulse:
    assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_unmapped_reads_zero:
    assert property (ack_o && !we_i && adr_i >= 8'h60 |-> dat_o == '0)
      else $error("unmapped read not zero");
  a_frame_holds_steady:
    assert property (frame_vld_o && !frame_done_i |=> frame_vld_o && $stable(frame_o))
      else $error("frame changed before done");
  a_bus_one_hot:
    assert property (frame_vld_o |-> $onehot(bus_sel_o)) else $error("bus select not one-hot");
  a_bus_matches_ctrl:
    assert property (frame_vld_o |-> bus_sel_o == (NUM_BUS'(1) << ctrl_r[CTRL_BUS_LO +: BW]))
      else $error("wrong bus selected");
  a_bus_off_disabled:
    assert property ((!ctrl_r[CTRL_EN]) [*4] |-> bus_sel_o == '0) else $error("bus on when off");
  a_ext_follows_ctrl:
    assert property (frame_vld_o |-> frame_o.ext == ctrl_r[CTRL_EXT]) else $error("id kind wrong");
  a_std_id_fits:
    assert property (frame_vld_o && !frame_o.ext |-> frame_o.id[28:11] == '0)
      else $error("standard id too wide");
  a_refused_resent:
    assert property (pend_r && frame_vld_o |-> frame_o.id == nid_r) else $error("not resent");
  a_irq_masked_off:
    assert property ((mask_r == '0) [*3] |-> !irq_o) else $error("irq with all masked");
endmodule
bind can_signal_send_packer send_packer_checker #(.NUM_BUS(NUM_BUS)) i_send_packer_checker (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .frame_o(frame_o), .frame_vld_o(frame_vld_o),
  .bus_sel_o(bus_sel_o), .frame_done_i(frame_done_i), .frame_ack_i(frame_ack_i), .irq_o(irq_o));

// *** sim/can_ctrl_model.sv ***
// behavioural can controller with receivers: answers frames after a delay
`timescale 1ns/1ps
module can_ctrl_model
  import can_send_pkg::*;
(
  input  wire logic       clk_i,   // system clock
  input  wire logic       rst_i,   // synchronous reset
  input  wire can_frame_t frame_i, // frame on offer
  input  wire logic       vld_i,   // frame request level
  input  wire logic [7:0] delay_i, // cycles before answering
  input  wire logic [3:0] nack_i,  // refusals before a node appears
  output logic            done_o,  // frame finished pulse
  output logic            ack_o    // acknowledge, meaningful with done only
);
  can_frame_t log_q[$]; // acknowledged frames in arrival order
  int         wait_c;   // cycles spent on the offered frame
  int         nack_c;   // refusals given so far
  // answer each frame once; ack toggles outside done so a stale value never helps
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      ack_o  <= 1'b0;
      wait_c <= 0;
      nack_c <= 0;
    end else if (!done_o && vld_i && wait_c >= delay_i) begin
      done_o <= 1'b1;
      ack_o  <= (nack_c >= nack_i);
      wait_c <= 0;
      if (nack_c >= nack_i) log_q.push_back(frame_i);
      else nack_c <= nack_c + 1;
    end else begin
      done_o <= 1'b0;
      ack_o  <= ~ack_o;
      wait_c <= (vld_i && !done_o) ? wait_c + 1 : 0;
    end
  end
endmodule

// *** sim/tb_can_signal_send_packer.sv ***
// self-checking bench for the can signal send packer
`timescale 1ns/1ps
module tb_can_signal_send_packer;
  import can_send_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [63:0] sval  = {32'h89ab_cdef, 32'h1234_5678}; // signal 1, signal 0
  logic [1:0]  snew  = 2'h0;
  can_frame_t  frame;
  logic        vld;
  logic [3:0]  bsel;
  logic        done;
  logic        fack;
  logic        irq;
  logic [7:0]  delay = 8'h03;
  logic [3:0]  nack  = 4'h2;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc_cnt = 0;
  int          prev_rise = 0; // cycle of the previous first-frame offer
  int          last_rise = 0; // cycle of the latest first-frame offer
  logic        vld_q = 1'b0;  // frame offer one cycle ago
  // a slow nominal clock rate shrinks the output periods so the run stays short
  localparam longint TB_CLK_HZ = 20_000;
  localparam int     TB_PERIOD = int'((TB_CLK_HZ * 10) / RATE_DHZ[NUM_RATES-1]);
  always #5 clk_i = ~clk_i;
  can_signal_send_packer #(.NUM_SIG(2), .SIG_W(32), .NUM_BUS(4), .CLK_FREQ_HZ(TB_CLK_HZ))
    i_can_signal_send_packer (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .sig_val_i(sval),
    .sig_new_i(snew), .frame_o(frame), .frame_vld_o(vld), .bus_sel_o(bsel),
    .frame_done_i(done), .frame_ack_i(fack), .irq_o(irq));
  can_ctrl_model i_can_ctrl_model (.clk_i(clk_i), .rst_i(rst_i), .frame_i(frame), .vld_i(vld),
    .delay_i(delay), .nack_i(nack), .done_o(done), .ack_o(fack));
  task automatic give_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // timeout, sample pulses and the cycle stamp of each first-frame offer
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    snew    <= {1'b0, cyc_cnt % 1000 == 0}; // signal 1 never delivers a sample
    vld_q   <= vld;
    if (vld && !vld_q && frame.id[10:0] == 11'h6f0) begin
      prev_rise <= last_rise;
      last_rise <= cyc_cnt;
    end
    if (cyc_cnt == 5_000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 4'hf, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, s, d, q);
  endtask
  task automatic wait_log(input int k);
    while (i_can_ctrl_model.log_q.size() < k) @(posedge clk_i);
  endtask
  initial begin
    logic [31:0] q;
    can_frame_t  f;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_CTRL, 32'h0);
    rd(REG_STATUS, 32'h0);
    rd(REG_ERR_CNT, 32'h0);
    rd(REG_SEND_CNT, 32'h0);
    rd(REG_CNT_CFG, 32'h0000_0700);
    wr(REG_CNT_CFG, 4'h3, 32'h0000_0000);
    wr(REG_FIRST_ID, 4'hf, 32'h0abc_def0);
    wr(REG_FIRST_ID, 4'h3, 32'h0000_1111);
    rd(REG_FIRST_ID, 32'h0abc_def0);
    wr(8'h60, 4'hf, 32'hffff_ffff);
    rd(8'h60, 32'h0);
    wr(REG_SIG_CFG, 4'hf, 32'h0000_23d0);
    wr(REG_SIG_CFG + 8'h04, 4'hf, 32'h0000_27c0);
    wr(REG_MASK, 4'hf, 32'h1 << ST_OVF);
    chk(bsel, 4'h0);
    // enabled, 100 Hz, extended ids, automatic identifiers, bus 2
    wr(REG_CTRL, 4'hf, 32'h0000_023f);
    // counter frame first, then one frame per signal
    wait_log(3);
    f = i_can_ctrl_model.log_q[0];
    chk({f.ext, f.id}, {1'b1, 29'h0abc_def0});
    chk(f.data, 64'h0000_0000_0000_0000);
    f = i_can_ctrl_model.log_q[1];
    chk(f.id, 29'h0abc_def1);
    chk(f.data, 64'h0000_0000_5678_0000);
    f = i_can_ctrl_model.log_q[2];
    chk(f.id, 29'h0abc_def2);
    chk(f.data, 64'h0000_0000_89ab_cdef);
    rd(REG_ERR_CNT, 32'h2);
    wb(1'b0, REG_STATUS, 4'hf, 32'h0, q);
    chk(q[1:0], 2'h3);
    chk(irq, 1'b1);
    wr(REG_MASK, 4'hf, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    wr(REG_MASK, 4'hf, 32'h1 << ST_OVF);
    wr(REG_STATUS, 4'hf, 32'h7);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    rd(REG_STATUS, 32'h0);
    sval <= {32'h89ab_cdef, 32'h0000_beef};
    nack <= 4'h0;
    wait_log(6);
    f = i_can_ctrl_model.log_q[3];
    chk(f.data, 64'h0000_0000_0000_0001);
    f = i_can_ctrl_model.log_q[4];
    chk(f.data, 64'h0000_0000_beef_0000);
    // standard ids, big-endian signal 0 with its msb at bit 23, counter big-endian
    wr(REG_SIG_CFG, 4'hf, 32'h0000_33d7);
    wr(REG_CTRL, 4'hf, 32'h0000_026f);
    wait_log(9);
    f = i_can_ctrl_model.log_q[6];
    chk({f.ext, f.id}, {1'b0, 29'h0000_06f0});
    chk(f.data, 64'h0000_0000_0000_0000);
    f = i_can_ctrl_model.log_q[7];
    chk(f.data, 64'h0000_0000_efbe_0000);
    chk(64'(last_rise - prev_rise), 64'(TB_PERIOD));
    rd(REG_ERR_CNT, 32'h2);
    wr(REG_CTRL, 4'hf, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(bsel, 4'h0);
    give_verdict();
  end
endmodule
